// ### rtl/pwc_pkg.sv
// Purpose: Shared constants and types for the multi-channel PWM counter.
// Assumes: One 100 MHz clock, no software-visible registers.
// Notes: Control arrives as plain ports grouped in packed structs.
// How it works
// - Enabling a center-aligned channel raises its event flag at once.
// - The counter runs 0 to period in the first period, then 1 to period.
// - A zero period written through the update port is ignored.
// - A channel disabled mid-period reports enabled until that period ends.
package pwc_pkg;

    // ------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------
    localparam int unsigned PWC_CNT_W = 16;
    localparam logic [15:0] PWC_CNT_FIRST = 16'h0000;
    localparam logic [15:0] PWC_CNT_RESTART = 16'h0001;
    localparam logic [15:0] PWC_PERIOD_RST = 16'h0000;
    localparam logic [15:0] PWC_ZERO_PERIOD = 16'h0000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic enable;
        logic disable_req;
        logic center_align_select;
        logic tick;
        logic upd_valid;
        logic [15:0] upd_period;
    } pwc_ctrl_t;

    typedef struct packed {
        logic channel_enable_status_bit;
        logic event_pulse;
        logic period_end;
        logic [15:0] count;
    } pwc_stat_t;

endpackage

// ### rtl/pwc_chan.sv
// Purpose: One PWM channel: period counter, enable status and events.
// Assumes: Ticks are one-cycle pulses in the system clock domain.
// Notes: Update values take effect at the next period boundary.
`timescale 1ns/1ps
module pwc_chan
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // Control
    input wire pwc_pkg::pwc_ctrl_t i_ctrl,
    // Status
    output pwc_pkg::pwc_stat_t o_stat
);

    typedef enum logic [1:0] {
        PWC_IDLE = 2'b00,
        PWC_RUN = 2'b01,
        PWC_DRAIN = 2'b10
    } pwc_state_t;

    pwc_state_t state_q, state_d;
    logic [15:0] cnt_q, cnt_d;
    logic [15:0] per_q, per_d;
    logic [15:0] pend_q, pend_d;
    logic pend_v_q, pend_v_d;
    logic ev_q, ev_d;
    logic end_q, end_d;
    logic wrap;

    assign wrap = i_ctrl.tick && (cnt_q >= per_q);

    // -------------------------------------------------------------
    // Next-state logic
    // -------------------------------------------------------------
    // A disable only stops the counter at the boundary, so status lags.
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        per_d = per_q;
        pend_d = pend_q;
        pend_v_d = pend_v_q;
        ev_d = 1'b0;
        end_d = 1'b0;
        // A zero period would make the wrap compare fire on every tick, so it is dropped.
        if (i_ctrl.upd_valid && i_ctrl.upd_period != pwc_pkg::PWC_ZERO_PERIOD)
        begin
            pend_d = i_ctrl.upd_period;
            pend_v_d = 1'b1;
        end
        unique case (state_q)
            PWC_IDLE:
            begin
                if (i_ctrl.enable)
                begin
                    state_d = PWC_RUN;
                    cnt_d = pwc_pkg::PWC_CNT_FIRST;
                    ev_d = i_ctrl.center_align_select;
                end
            end
            PWC_RUN, PWC_DRAIN:
            begin
                if (i_ctrl.disable_req && state_q == PWC_RUN)
                begin
                    state_d = PWC_DRAIN;
                end
                if (wrap)
                begin
                    end_d = 1'b1;
                    ev_d = !i_ctrl.center_align_select;
                    cnt_d = pwc_pkg::PWC_CNT_RESTART;
                    if (pend_v_d)
                    begin
                        per_d = pend_d;
                        pend_v_d = 1'b0;
                    end
                    if (state_q == PWC_DRAIN || i_ctrl.disable_req)
                    begin
                        state_d = PWC_IDLE;
                    end
                end
                else if (i_ctrl.tick)
                begin
                    cnt_d = cnt_q + 16'h0001;
                end
            end
            default:
            begin
                state_d = PWC_IDLE;
            end
        endcase
    end

    // -------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state_q <= PWC_IDLE;
            cnt_q <= pwc_pkg::PWC_CNT_FIRST;
            per_q <= pwc_pkg::PWC_PERIOD_RST;
            pend_q <= pwc_pkg::PWC_PERIOD_RST;
            pend_v_q <= 1'b0;
            ev_q <= 1'b0;
            end_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            per_q <= per_d;
            pend_q <= pend_d;
            pend_v_q <= pend_v_d;
            ev_q <= ev_d;
            end_q <= end_d;
        end
    end

    // Status outputs come from flip-flops.
    assign o_stat.channel_enable_status_bit = (state_q != PWC_IDLE);
    assign o_stat.event_pulse = ev_q;
    assign o_stat.period_end = end_q;
    assign o_stat.count = cnt_q;

endmodule

// ### rtl/pwc_top.sv
// Purpose: Multi-channel PWM counter block with per-channel status.
// Assumes: Period loads arrive only on the update port.
// Notes: Waveform comparators sit outside this block.
`timescale 1ns/1ps
module pwc_top
#(
    parameter int unsigned NUM_CH = 7
)
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // Per-channel control
    input wire pwc_pkg::pwc_ctrl_t [NUM_CH-1:0] i_ctrl,
    // Per-channel status
    output pwc_pkg::pwc_stat_t [NUM_CH-1:0] o_stat
);

    // -------------------------------------------------------------
    // Channels
    // -------------------------------------------------------------
    // Channels are independent; each gets its own counter instance.
    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_ch
        pwc_chan u_chan
        (
            .i_sys_clk(i_sys_clk),
            .i_nrst(i_nrst),
            .i_ctrl(i_ctrl[g]),
            .o_stat(o_stat[g])
        );
    end

endmodule

// ### verification/pwc_properties.sv
// Purpose: Timing properties of PWM channel 0.
// Assumes: The bench exercises channel 0 only.
// Notes: Other channels share the logic, so one is watched.
`timescale 1ns/1ps
module pwc_chk
#(
    parameter int unsigned NUM_CH = 7
)
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // Watched ports
    input wire pwc_pkg::pwc_ctrl_t [NUM_CH-1:0] i_ctrl,
    input wire pwc_pkg::pwc_stat_t [NUM_CH-1:0] o_stat
);
    // Channel 0 views keep the properties short.
    wire pwc_pkg::pwc_ctrl_t c = i_ctrl[0];
    wire pwc_pkg::pwc_stat_t s = o_stat[0];
    default clocking @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_nrst);
    // An enable that is taken because the channel is idle.
    sequence s_start;
        !s.channel_enable_status_bit && c.enable;
    endsequence
    chk_center_event:
        assert property (s_start ##0 c.center_align_select |=> s.event_pulse)
        else $error("no event after center enable");
    chk_start_zero:
        assert property (s_start |=> s.channel_enable_status_bit
            && s.count == 16'h0000) else $error("bad start count");
    chk_restart_one:
        assert property (s.period_end |-> s.count == 16'h0001)
        else $error("restart not at one");
    chk_count_step:
        assert property (s.channel_enable_status_bit && c.tick |=>
            s.period_end || s.count == $past(s.count) + 16'h0001)
        else $error("count did not step");
    chk_status_hold:
        assert property ($fell(s.channel_enable_status_bit) |-> s.period_end)
        else $error("status dropped before wrap");
    // The alignment that counts is the one seen at the wrap edge itself.
    chk_left_event:
        assert property (s.period_end && !$past(c.center_align_select)
            |-> s.event_pulse) else $error("no event at left wrap");
    // A disable without a wrap must leave the status bit standing.
    chk_disable_hold:
        assert property (s.channel_enable_status_bit && c.disable_req
            && !c.tick |=> s.channel_enable_status_bit)
        else $error("status dropped at disable");
endmodule
bind pwc_top pwc_chk #(.NUM_CH(NUM_CH)) i_chk (.i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst), .i_ctrl(i_ctrl), .o_stat(o_stat));

// ### verification/pwc_tb_top.sv
// Purpose: Self-checking bench for one PWM channel.
// Assumes: Inputs change on the falling edge.
// Notes: Rows pair a control word with the status it must give.
`timescale 1ns/1ps
module pwc_tb_top;
    logic i_sys_clk = 1'b0;
    logic i_nrst = 1'b0;
    pwc_pkg::pwc_ctrl_t [0:0] i_ctrl = '0;
    pwc_pkg::pwc_stat_t [0:0] o_stat;
    int mismatches = 0;
    int n_checks = 0;
    int cyc = 0;
    // One row pairs a control word with the status it must give.
    typedef struct packed {
        pwc_pkg::pwc_ctrl_t ctrl;
        pwc_pkg::pwc_stat_t stat;
    } pwc_row_t;
    // Center enable, period 3, a refused zero, a disable mid-period, then
    // a left re-enable that keeps period 3 and shows the longer first period.
    // Rows 18 and 19 run after the mid-run reset.
    pwc_row_t rows [20] = '{
        {21'h140000, 19'h60000},
        {21'h050003, 19'h40000},
        {21'h060000, 19'h50001},
        {21'h060000, 19'h40002},
        {21'h060000, 19'h40003},
        {21'h040000, 19'h40003},
        {21'h050000, 19'h40003},
        {21'h060000, 19'h50001},
        {21'h060000, 19'h40002},
        {21'h060000, 19'h40003},
        {21'h0C0000, 19'h40003},
        {21'h060000, 19'h10001},
        {21'h100000, 19'h40000},
        {21'h020000, 19'h40001},
        {21'h020000, 19'h40002},
        {21'h020000, 19'h40003},
        {21'h020000, 19'h70001},
        {21'h020000, 19'h40002},
        {21'h100000, 19'h40000},
        {21'h020000, 19'h70001}
    };
    // Free-running system clock.
    always #5 i_sys_clk = ~i_sys_clk;
    pwc_top #(.NUM_CH(1)) i_dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
        .i_ctrl(i_ctrl), .o_stat(o_stat));
    // Compare one status word and count the outcome.
    task automatic check(input logic [18:0] seen, input logic [18:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Drive each row for one cycle and check the settled result.
    task automatic run(input int a, input int b);
        for (int i = a; i <= b; i++)
        begin
            i_ctrl[0] = rows[i].ctrl;
            @(negedge i_sys_clk);
            check(o_stat[0], rows[i].stat);
        end
    endtask
    task automatic summarize;
        if (mismatches == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // A hang is cut short well past the expected 23 cycles.
    always @(posedge i_sys_clk)
    begin
        cyc++;
        if (cyc == 400)
        begin
            mismatches++;
            summarize();
        end
    end
    // Table first, then a mid-run reset and a left-aligned start.
    initial
    begin
        repeat (2) @(negedge i_sys_clk);
        i_nrst = 1'b1;
        run(0, 17);
        i_ctrl[0] = '0;
        i_nrst = 1'b0;
        @(negedge i_sys_clk);
        check(o_stat[0], 19'h00000);
        i_nrst = 1'b1;
        run(18, 19);
        summarize();
    end
endmodule
